//--- verilog/pld_consts.vh
`ifndef PLD_CONSTS_VH
`define PLD_CONSTS_VH

`define PLD_ADDR_W        10
`define PLD_IN0_HI_OFS    10'h153
`define PLD_IN0_LO_OFS    10'h154
`define PLD_IN1_HI_OFS    10'h155
`define PLD_IN1_LO_OFS    10'h156
`define PLD_IN2_HI_OFS    10'h157
`define PLD_IN2_LO_OFS    10'h158
`define PLD_FB_HI_OFS     10'h159
`define PLD_FB_LO_OFS     10'h15a

`define PLD_HI_MSB        5
`define PLD_HI_LSB        0
`define PLD_LO_MSB        7
`define PLD_LO_LSB        0
`define PLD_HI_W          6

`define PLD_IN0_RESET     14'h0078
`define PLD_IN1_RESET     14'h0096
`define PLD_IN2_RESET     14'h0096
`define PLD_FB_RESET      14'h0078

`define PLD_SEL_IN0       2'h0
`define PLD_SEL_IN1       2'h1
`define PLD_SEL_IN2       2'h2

`endif

//--- verilog/pld_loop1_divider_regs.v
`include "pld_consts.vh"

module pld_loop1_divider_regs
#(
  parameter DIV_W = 14
)
(
  input  wire              mclk,
  input  wire              reset_n,
  input  wire [9:0]        regAddr,
  input  wire [7:0]        regWrData,
  input  wire              regWrStb,
  input  wire              regRdStb,
  output reg  [7:0]        regRdData,
  input  wire [1:0]        refInputSel,
  output wire [DIV_W-1:0]  input0RefDivider,
  output wire [DIV_W-1:0]  input1RefDivider,
  output wire [DIV_W-1:0]  input2RefDivider,
  output reg  [DIV_W-1:0]  activeRefDivider,
  output wire [DIV_W-1:0]  loop1FeedbackDivider,
  output reg               activeRefDivValid,
  output reg               loop1FbDivValid
);

  // divider entries: reference inputs 0, 1 and 2, then the feedback divider
  localparam NDIV  = 4;
  localparam RST_W = 14;
  localparam HI_W  = `PLD_HI_W;
  localparam LO_W  = DIV_W - `PLD_HI_W;
  localparam AW    = `PLD_ADDR_W;

  // address of the high byte of each entry
  localparam [NDIV*AW-1:0] HI_OFS =
  {
    `PLD_FB_HI_OFS,
    `PLD_IN2_HI_OFS,
    `PLD_IN1_HI_OFS,
    `PLD_IN0_HI_OFS
  };

  // address of the low byte of each entry
  localparam [NDIV*AW-1:0] LO_OFS =
  {
    `PLD_FB_LO_OFS,
    `PLD_IN2_LO_OFS,
    `PLD_IN1_LO_OFS,
    `PLD_IN0_LO_OFS
  };

  // power-up ratio of each entry
  localparam [NDIV*RST_W-1:0] RST_VAL =
  {
    `PLD_FB_RESET,
    `PLD_IN2_RESET,
    `PLD_IN1_RESET,
    `PLD_IN0_RESET
  };

  // one-hot address decode per entry
  wire [NDIV-1:0]       hiHit;
  wire [NDIV-1:0]       loHit;
  // all four dividers side by side, entry 0 in the low bits
  wire [NDIV*DIV_W-1:0] divBus;
  // read-back byte of each entry, zero when not addressed
  wire [NDIV*8-1:0]     entryRd;
  reg  [7:0]            rdData_nxt;
  reg  [DIV_W-1:0]      activeRef_nxt;
  wire                  activeRefZero;
  wire                  fbZero;
  integer               k;

  genvar                i;

  // one storage entry per divider
  generate
    for (i = 0; i < NDIV; i = i + 1)
    begin : gen_div
      reg  [HI_W-1:0] hi_r;
      reg  [LO_W-1:0] lo_r;
      wire            hiWr;
      wire            loWr;
      wire [7:0]      hiRd;

      assign hiHit[i] = (regAddr == HI_OFS[i*AW +: AW]);
      assign loHit[i] = (regAddr == LO_OFS[i*AW +: AW]);
      assign hiWr     = regWrStb & hiHit[i];
      assign loWr     = regWrStb & loHit[i];
      // reserved high-byte bits are never stored
      assign hiRd     = {{(8-HI_W){1'b0}}, hi_r};

      // byte writes land one at a time; the pair is not staged
      always @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          hi_r <= RST_VAL[i*RST_W+LO_W +: HI_W];
          lo_r <= RST_VAL[i*RST_W +: LO_W];
        end
        else
        begin
          if (hiWr)
          begin
            hi_r <= regWrData[`PLD_HI_MSB:`PLD_HI_LSB];
          end
          if (loWr)
          begin
            lo_r <= regWrData[`PLD_LO_MSB:`PLD_LO_LSB];
          end
        end
      end

      // the full value is the high field above the low byte
      assign divBus[i*DIV_W +: DIV_W] = {hi_r, lo_r};
      assign entryRd[i*8 +: 8] =
        hiHit[i] ? hiRd :
        loHit[i] ? lo_r : 8'h00;
    end
  endgenerate

  // per-divider outputs straight from the flip-flops
  assign input0RefDivider     = divBus[0*DIV_W +: DIV_W];
  assign input1RefDivider     = divBus[1*DIV_W +: DIV_W];
  assign input2RefDivider     = divBus[2*DIV_W +: DIV_W];
  assign loop1FeedbackDivider = divBus[3*DIV_W +: DIV_W];

  // only one entry decodes any address, so the bytes merge by or
  always @*
  begin
    rdData_nxt = 8'h00;
    for (k = 0; k < NDIV; k = k + 1)
    begin
      rdData_nxt = rdData_nxt | entryRd[k*8 +: 8];
    end
  end

  // select code 3 is not an input; it falls back to input 0
  always @*
  begin
    case (refInputSel)
      `PLD_SEL_IN0:
      begin
        activeRef_nxt = input0RefDivider;
      end
      `PLD_SEL_IN1:
      begin
        activeRef_nxt = input1RefDivider;
      end
      `PLD_SEL_IN2:
      begin
        activeRef_nxt = input2RefDivider;
      end
      default:
      begin
        activeRef_nxt = input0RefDivider;
      end
    endcase
  end

  // zero is a reserved ratio; the flags tell the loop not to use it
  assign activeRefZero = (activeRef_nxt == {DIV_W{1'b0}});
  assign fbZero        = (loop1FeedbackDivider == {DIV_W{1'b0}});

  // read data stands for the one cycle after the strobe, zero otherwise
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regRdData <= 8'h00;
    end
    else
    begin
      regRdData <= regRdStb ? rdData_nxt : 8'h00;
    end
  end

  // the selected divider lags the select by one cycle
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      activeRefDivider <= `PLD_IN0_RESET;
    end
    else
    begin
      activeRefDivider <= activeRef_nxt;
    end
  end

  // flags the selected reference ratio as usable
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      activeRefDivValid <= 1'b1;
    end
    else
    begin
      activeRefDivValid <= !activeRefZero;
    end
  end

  // flags the feedback ratio as usable
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loop1FbDivValid <= 1'b1;
    end
    else
    begin
      loop1FbDivValid <= !fbZero;
    end
  end

endmodule // pld_loop1_divider_regs

//--- tb/pld_chk_properties.sv
module pld_chk(
  input logic mclk, reset_n, regWrStb, regRdStb, activeRefDivValid,
  input logic loop1FbDivValid,
  input logic [9:0] regAddr,
  input logic [7:0] regWrData, regRdData,
  input logic [1:0] refInputSel,
  input logic [13:0] input0RefDivider, input1RefDivider, input2RefDivider,
  input logic [13:0] activeRefDivider, loop1FeedbackDivider);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  AST_IN0: assert property (regWrStb && regAddr == 10'h154 |=>
    input0RefDivider[7:0] == $past(regWrData)) else $error("in0");
  AST_IN1: assert property (regWrStb && regAddr == 10'h155 |=>
    input1RefDivider[13:8] == $past(regWrData[5:0])) else $error("in1");
  AST_IN2: assert property (refInputSel == 2'h2 |=>
    activeRefDivider == $past(input2RefDivider)) else $error("in2");
  AST_FB: assert property (regWrStb && regAddr == 10'h15a |=>
    loop1FeedbackDivider[7:0] == $past(regWrData)) else $error("fb");
  AST_VLD: assert property (activeRefDivValid ==
    (activeRefDivider != 0)) else $error("vld");
  AST_RSV: assert property (regRdStb && regAddr[0] |=>
    regRdData[7:6] == 2'h0) else $error("rsv");
  AST_HI0: assert property (regWrStb && regAddr == 10'h153 |=>
    input0RefDivider[13:8] == $past(regWrData[5:0])) else $error("hi0");
  AST_FBV: assert property (1'b1 |=> loop1FbDivValid ==
    ($past(loop1FeedbackDivider) != 14'h0)) else $error("fbv");
endmodule // pld_chk
bind pld_loop1_divider_regs pld_chk i_chk(.*);

//--- tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset_n = 0, regWrStb = 0, regRdStb = 0;
  logic activeRefDivValid, loop1FbDivValid;
  logic [9:0] regAddr = 0;
  logic [7:0] regWrData = 0, regRdData;
  logic [1:0] refInputSel = 0;
  logic [13:0] input0RefDivider, input1RefDivider, input2RefDivider;
  logic [13:0] activeRefDivider, loop1FeedbackDivider;
  int failures = 0, compares = 0;
  always #12.5 mclk = ~mclk;
  pld_loop1_divider_regs i_dut(.*);
  task cmp(input logic [13:0] g, e);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask
  // one strobe cycle; read data is sampled in the cycle after it
  task acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    {regWrStb, regRdStb, regAddr, regWrData} <= {w, !w, a, d};
    @(posedge mclk);
    {regWrStb, regRdStb} <= 2'h0;
    #1;
  endtask
  task t_reset;
    cmp(input0RefDivider, 120);
    cmp(input1RefDivider, 150);
    cmp(input2RefDivider, 150);
    cmp(loop1FeedbackDivider, 120);
    cmp(activeRefDivider, 120);
    cmp(activeRefDivValid, 1);
    cmp(loop1FbDivValid, 1);
    cmp(regRdData, 0);
  endtask
  task t_fbzero;
    cmp(loop1FbDivValid, 1);
    acc(1, 10'h159, 0);
    acc(1, 10'h15a, 0);
    @(posedge mclk);
    #1;
    cmp(loop1FeedbackDivider, 0);
    cmp(loop1FbDivValid, 0);
  endtask
  task t_midreset;
    @(posedge mclk);
    reset_n <= 0;
    repeat (2) @(posedge mclk);
    reset_n <= 1;
    t_reset;
    acc(0, 10'h154, 0);
    cmp(regRdData, 8'h78);
  endtask
  task t_rw;
    for (int i = 0; i < 4; i++)
    begin
      acc(1, 10'h153 + 2 * i, 8'hc0 + i);
      acc(1, 10'h154 + 2 * i, i);
      acc(0, 10'h153 + 2 * i, 0);
      cmp(regRdData, i);
      @(posedge mclk);
      #1;
      cmp(regRdData, 0);
    end
    cmp(loop1FeedbackDivider, 14'h0303);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge mclk);
      refInputSel <= s;
      repeat (2) @(posedge mclk);
      #1;
      cmp(activeRefDivider, s % 3 ? {s[5:0], s[7:0]} : 0);
      cmp(activeRefDivValid, s % 3 != 0);
    end
    acc(1, 10'h15b, 8'hff);
    acc(0, 10'h15b, 0);
    cmp(regRdData, 0);
  endtask
  task results;
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    reset_n <= 1;
    t_reset;
    t_rw;
    t_fbzero;
    t_midreset;
    results;
  end
  initial
  begin
    #20us;
    failures++;
    results;
  end
endmodule // tb_top
